// ===== verilog/tol_trip_logic.sv
// machine_thermal_overload_fn output stage: thresholds, trip delay, blocking,
// condition and setting-fault reporting, counters, APB registers, interrupt
// assumes thermal capacity, current and setting checks come synchronous to pclk
// Contract
// - Alarm, inhibit and trip outputs follow from thermal capacity compared to the thresholds.
// - Alarm 1 rises at its threshold, 0.1 % steps, 40 % default, if enabled.
// - Alarm 2 rises at its own threshold, 40 % default, if enabled.
// - Restart inhibit rises at its threshold, 80 % default, if enabled.
// - Trip follows trip threshold after added delay 0..3600 s, 5 ms steps.
// - Blocking input is sampled at each program cycle start before pick-up.
// - Pick-up without blocking raises start and runs the trip delay.
// - Pick-up with blocking raises blocked and nothing more.
// - Blocking during start clears start and releases as a pick-up reset.
// - Report condition code; normal condition drives no alarm, inhibit, trip or blocked output.
// - Report logical_node behaviour mode when individual mode is allowed.
// - Classify motor load as light, normal, overloading or high overload.
// - Bad service_factor setting flags fault and substitutes 1.0.
// - Bad ambient settings flag fault and substitute 1.0.
// - Bad rated current setting flags fault and substitutes 1.0.
// - Inconsistent ambient k setting raises its own fault flag.
// - Resettable counters count trip, alarm 1, alarm 2, inhibit, blocked.
`include "tol_params.svh"
module tol_trip_logic #(
  parameter int STEP_CYC = (`TOL_STEP_NS + `TOL_CLK_NS - 1) / `TOL_CLK_NS,
  parameter int CNT_W    = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             prog_tick,
  input  wire logic [15:0]      thermal_cap,
  input  wire logic [15:0]      meas_current,
  input  wire logic             block_in,
  input  wire logic             allow_ln_mode,
  input  wire tol_pkg::tol_fix_t service_factor_set,
  input  wire logic             service_factor_bad,
  input  wire tol_pkg::tol_fix_t ambient_k_set,
  input  wire logic             ambient_bad,
  input  wire tol_pkg::tol_fix_t rated_set,
  input  wire logic             rated_bad,
  input  wire logic             ambient_k_incons,
  output logic                  alarm1,
  output logic                  alarm2,
  output logic                  inhibit,
  output logic                  trip,
  output logic                  start,
  output logic                  blocked,
  output tol_pkg::tol_fix_t     service_factor_used,
  output tol_pkg::tol_fix_t     ambient_k_used,
  output tol_pkg::tol_fix_t     rated_used,
  output logic                  irq
);
  import tol_pkg::*;

  localparam int NCNT = 5;
  // control and settings
  logic [2:0]  en;
  logic [2:0]  mode;
  tol_level_t  lvl_a1, lvl_a2, lvl_inh, lvl_trip;
  logic [19:0] trip_dly;
  logic [15:0] pickup_cur;
  logic [5:0]  irq_stat, irq_en;
  logic [CNT_W-1:0] cnt [NCNT];
  logic [2:0]  next_en;
  logic [2:0]  next_mode;
  tol_level_t  next_lvl_a1, next_lvl_a2, next_lvl_inh, next_lvl_trip;
  logic [19:0] next_trip_dly;
  logic [15:0] next_pickup_cur;
  logic [5:0]  next_irq_stat, next_irq_en;
  logic [CNT_W-1:0] next_cnt [NCNT];
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_irq;

  // protection state
  logic [31:0] step_cnt, next_step_cnt;
  logic [19:0] elapsed, next_elapsed;
  tol_cond_e   cond, next_cond;
  tol_motor_e  motor, next_motor;
  tol_behav_e  behav, next_behav;
  logic [3:0]  fault, next_fault;
  logic        next_alarm1, next_alarm2, next_inhibit, next_trip;
  logic        next_start, next_blocked;
  tol_fix_t    next_sf_used, next_amb_used, next_rated_used;

  function automatic logic reach(input logic [15:0] cap, input tol_level_t lvl);
    return cap >= {5'h00, lvl};
  endfunction

  function automatic tol_behav_e to_behav(input logic [2:0] code);
    unique case (code)
      3'h1:    return tol_behav_blocked;
      3'h2:    return tol_behav_test;
      3'h3:    return tol_behav_test_blocked;
      3'h4:    return tol_behav_off;
      default: return tol_behav_on;
    endcase
  endfunction

  function automatic tol_fix_t pick(input logic bad, input tol_fix_t v);
    return bad ? `TOL_ONE_POINT_ZERO : v;
  endfunction

  logic wr_acc, rd_acc;
  logic [5:0] ev;
  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & ~pready & ~pwrite;
  // rising edges of the five counted outputs plus any setting fault
  assign ev = {|(next_fault & ~fault), next_blocked & ~blocked,
               next_inhibit & ~inhibit, next_alarm2 & ~alarm2,
               next_alarm1 & ~alarm1, next_trip & ~trip};

  always_comb begin
    logic pick_up, blk_eff, off;
    off             = (behav == tol_behav_off);
    blk_eff         = block_in | (behav == tol_behav_blocked) |
                      (behav == tol_behav_test_blocked);
    pick_up         = reach(thermal_cap, lvl_trip);
    next_step_cnt   = step_cnt;
    next_elapsed    = elapsed;
    next_start      = start;
    next_blocked    = blocked;
    next_trip       = trip;
    next_alarm1     = alarm1;
    next_alarm2     = alarm2;
    next_inhibit    = inhibit;
    next_cond       = cond;
    next_motor      = motor;
    next_behav      = allow_ln_mode ? to_behav(mode) : tol_behav_on;
    next_fault      = {ambient_k_incons, rated_bad, ambient_bad, service_factor_bad};
    next_sf_used    = pick(service_factor_bad, service_factor_set);
    next_amb_used   = pick(ambient_bad, ambient_k_set);
    next_rated_used = pick(rated_bad, rated_set);
    // the delay runs in 5 ms steps counted off pclk
    if (start && elapsed < trip_dly) begin
      if (step_cnt >= 32'(STEP_CYC - 1)) begin
        next_step_cnt = 32'h0;
        next_elapsed  = elapsed + 20'h1;
      end else begin
        next_step_cnt = step_cnt + 32'h1;
      end
    end
    if (start && elapsed >= trip_dly) begin
      next_trip = 1'b1;
    end
    if (prog_tick) begin
      if (pick_up && !blk_eff && !off) begin
        next_start   = 1'b1;
        next_blocked = 1'b0;
      end else begin
        // blocked pick-up or reset: release start and the delay
        next_start    = 1'b0;
        next_trip     = 1'b0;
        next_elapsed  = 20'h0;
        next_step_cnt = 32'h0;
        next_blocked  = pick_up & !off;
      end
      next_alarm1  = en[`TOL_CTRL_EN_A1] & reach(thermal_cap, lvl_a1) & !off;
      next_alarm2  = en[`TOL_CTRL_EN_A2] & reach(thermal_cap, lvl_a2) & !off;
      next_inhibit = en[`TOL_CTRL_EN_INH] & reach(thermal_cap, lvl_inh) & !off;
      if (meas_current < `TOL_LIGHT_LOAD) begin
        next_motor = tol_motor_light;
      end else if (meas_current > `TOL_HIGH_LOAD) begin
        next_motor = tol_motor_high;
      end else if (meas_current > pickup_cur) begin
        next_motor = tol_motor_overload;
      end else begin
        next_motor = tol_motor_normal;
      end
    end
    if (next_blocked) begin
      next_cond = tol_cond_blocked;
    end else if (next_trip) begin
      next_cond = tol_cond_trip;
    end else if (next_inhibit) begin
      next_cond = tol_cond_inhibit;
    end else if (next_alarm2) begin
      next_cond = tol_cond_alarm2;
    end else if (next_alarm1) begin
      next_cond = tol_cond_alarm1;
    end else begin
      next_cond = tol_cond_normal;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt            <= 32'h0;
      elapsed             <= 20'h0;
      start               <= 1'b0;
      blocked             <= 1'b0;
      trip                <= 1'b0;
      alarm1              <= 1'b0;
      alarm2              <= 1'b0;
      inhibit             <= 1'b0;
      cond                <= tol_cond_normal;
      motor               <= tol_motor_light;
      behav               <= tol_behav_on;
      fault               <= 4'h0;
      service_factor_used <= `TOL_ONE_POINT_ZERO;
      ambient_k_used      <= `TOL_ONE_POINT_ZERO;
      rated_used          <= `TOL_ONE_POINT_ZERO;
    end else begin
      step_cnt            <= next_step_cnt;
      elapsed             <= next_elapsed;
      start               <= next_start;
      blocked             <= next_blocked;
      trip                <= next_trip;
      alarm1              <= next_alarm1;
      alarm2              <= next_alarm2;
      inhibit             <= next_inhibit;
      cond                <= next_cond;
      motor               <= next_motor;
      behav               <= next_behav;
      fault               <= next_fault;
      service_factor_used <= next_sf_used;
      ambient_k_used      <= next_amb_used;
      rated_used          <= next_rated_used;
    end
  end

  // register file; pready is registered, so every access takes three cycles
  always_comb begin
    logic cnt_clr;
    cnt_clr         = 1'b0;
    next_en         = en;
    next_mode       = mode;
    next_lvl_a1     = lvl_a1;
    next_lvl_a2     = lvl_a2;
    next_lvl_inh    = lvl_inh;
    next_lvl_trip   = lvl_trip;
    next_trip_dly   = trip_dly;
    next_pickup_cur = pickup_cur;
    next_irq_en     = irq_en;
    next_prdata     = 32'h0;
    next_pready     = psel & penable & ~pready;
    next_pslverr    = 1'b0;
    next_irq_stat   = irq_stat;
    if (wr_acc) begin
      unique case (paddr)
        `TOL_OFS_CTRL: begin
          next_en   = pwdata[2:0];
          next_mode = pwdata[`TOL_CTRL_MODE_HI:`TOL_CTRL_MODE_LO];
        end
        `TOL_OFS_LVL_A1:   next_lvl_a1 = pwdata[10:0];
        `TOL_OFS_LVL_A2:   next_lvl_a2 = pwdata[10:0];
        `TOL_OFS_LVL_INH:  next_lvl_inh = pwdata[10:0];
        `TOL_OFS_LVL_TRIP: next_lvl_trip = pwdata[10:0];
        `TOL_OFS_TRIP_DLY: next_trip_dly = pwdata[19:0];
        `TOL_OFS_PICKUP:   next_pickup_cur = pwdata[15:0];
        `TOL_OFS_IRQ_EN:   next_irq_en = pwdata[5:0];
        `TOL_OFS_IRQ_CLR:  next_irq_stat = irq_stat & ~pwdata[5:0];
        `TOL_OFS_CNT_CLR:  cnt_clr = 1'b1;
        default:           ;
      endcase
    end
    // an event in the clearing cycle survives the clear
    next_irq_stat = next_irq_stat | ev;
    for (int i = 0; i < NCNT; i++) begin
      next_cnt[i] = cnt_clr ? '0 : cnt[i];
      if (ev[i]) begin
        next_cnt[i] = next_cnt[i] + CNT_W'(1);
      end
    end
    if (rd_acc) begin
      unique case (paddr)
        `TOL_OFS_CTRL:     next_prdata = {25'h0, mode, 1'b0, en};
        `TOL_OFS_LVL_A1:   next_prdata = {21'h0, lvl_a1};
        `TOL_OFS_LVL_A2:   next_prdata = {21'h0, lvl_a2};
        `TOL_OFS_LVL_INH:  next_prdata = {21'h0, lvl_inh};
        `TOL_OFS_LVL_TRIP: next_prdata = {21'h0, lvl_trip};
        `TOL_OFS_TRIP_DLY: next_prdata = {12'h0, trip_dly};
        `TOL_OFS_PICKUP:   next_prdata = {16'h0, pickup_cur};
        `TOL_OFS_STATUS:   next_prdata = {10'h0, start, blocked, trip, inhibit, alarm2,
                                          alarm1, fault, 1'b0, behav, 2'h0, motor,
                                          1'b0, cond};
        `TOL_OFS_IRQ_STAT: next_prdata = {26'h0, irq_stat};
        `TOL_OFS_IRQ_EN:   next_prdata = {26'h0, irq_en};
        `TOL_OFS_IRQ_CLR, `TOL_OFS_CNT_CLR: next_prdata = 32'h0;
        default: begin
          if (paddr >= `TOL_OFS_CNT0 && paddr < `TOL_OFS_CNT0 + 12'h014 &&
              paddr[1:0] == 2'h0) begin
            next_prdata = 32'(cnt[3'(paddr[4:2] - 3'h4)]);
          end else begin
            next_pslverr = 1'b1;
          end
        end
      endcase
    end
    if (wr_acc) begin
      next_pslverr = 1'b0;
    end
    next_irq = |(next_irq_stat & next_irq_en);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en         <= 3'h0;
      mode       <= 3'h0;
      lvl_a1     <= `TOL_RST_LVL_A1;
      lvl_a2     <= `TOL_RST_LVL_A2;
      lvl_inh    <= `TOL_RST_LVL_INH;
      lvl_trip   <= `TOL_RST_LVL_TRIP;
      trip_dly   <= 20'h0;
      pickup_cur <= `TOL_RST_PICKUP;
      irq_stat   <= 6'h0;
      irq_en     <= 6'h0;
      prdata     <= 32'h0;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      irq        <= 1'b0;
      for (int i = 0; i < NCNT; i++) begin
        cnt[i] <= '0;
      end
    end else begin
      en         <= next_en;
      mode       <= next_mode;
      lvl_a1     <= next_lvl_a1;
      lvl_a2     <= next_lvl_a2;
      lvl_inh    <= next_lvl_inh;
      lvl_trip   <= next_lvl_trip;
      trip_dly   <= next_trip_dly;
      pickup_cur <= next_pickup_cur;
      irq_stat   <= next_irq_stat;
      irq_en     <= next_irq_en;
      prdata     <= next_prdata;
      pready     <= next_pready;
      pslverr    <= next_pslverr;
      irq        <= next_irq;
      for (int i = 0; i < NCNT; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_alarm1_gate;
    prog_tick && !en[`TOL_CTRL_EN_A1] |=> !alarm1;
  endproperty
  a_alarm1_gate: assert property (p_alarm1_gate) else $error("alarm1 while disabled");

  property p_alarm2_level;
    prog_tick && en[`TOL_CTRL_EN_A2] && behav != tol_behav_off
      && reach(thermal_cap, lvl_a2) |=> alarm2;
  endproperty
  a_alarm2_level: assert property (p_alarm2_level) else $error("alarm2 missed");

  property p_inhibit_release;
    prog_tick && !reach(thermal_cap, lvl_inh) |=> !inhibit;
  endproperty
  a_inhibit_release: assert property (p_inhibit_release) else $error("inhibit held");

  property p_trip_needs_start;
    trip |-> start;
  endproperty
  a_trip_needs_start: assert property (p_trip_needs_start) else $error("trip alone");

  property p_zero_delay;
    $rose(start) && trip_dly == 20'h0 |=> trip;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay trip late");

  property p_block_clears_start;
    prog_tick && block_in |=> !start && !trip && elapsed == 20'h0;
  endproperty
  a_block_clears_start: assert property (p_block_clears_start) else $error("start kept");

  property p_blocked_excl;
    blocked |-> !start;
  endproperty
  a_blocked_excl: assert property (p_blocked_excl) else $error("blocked with start");

  property p_cond_normal;
    cond == tol_cond_normal |-> !(alarm1 | alarm2 | inhibit | trip | blocked);
  endproperty
  a_cond_normal: assert property (p_cond_normal) else $error("output in normal");

  property p_sf_sub;
    service_factor_bad |=> service_factor_used == `TOL_ONE_POINT_ZERO && fault[0];
  endproperty
  a_sf_sub: assert property (p_sf_sub) else $error("service factor not substituted");

  property p_irq;
    $rose(trip) |-> ##[1:2] irq_stat[0];
  endproperty
  a_irq: assert property (p_irq) else $error("trip event not latched");
endmodule

// ===== verilog/tol_params.svh
// constants of the thermal overload trip logic: offsets, fields, resets, timing
// assumes inclusion by the design top and the bench only
`ifndef TOL_PARAMS_SVH
`define TOL_PARAMS_SVH
`define TOL_OFS_CTRL      12'h000
`define TOL_OFS_LVL_A1    12'h004
`define TOL_OFS_LVL_A2    12'h008
`define TOL_OFS_LVL_INH   12'h00c
`define TOL_OFS_LVL_TRIP  12'h010
`define TOL_OFS_TRIP_DLY  12'h014
`define TOL_OFS_PICKUP    12'h018
`define TOL_OFS_STATUS    12'h01c
`define TOL_OFS_IRQ_STAT  12'h020
`define TOL_OFS_IRQ_EN    12'h024
`define TOL_OFS_IRQ_CLR   12'h028
`define TOL_OFS_CNT_CLR   12'h02c
`define TOL_OFS_CNT0      12'h030
`define TOL_CTRL_EN_A1    0
`define TOL_CTRL_EN_A2    1
`define TOL_CTRL_EN_INH   2
`define TOL_CTRL_MODE_LO  4
`define TOL_CTRL_MODE_HI  6
`define TOL_ST_COND_LO    0
`define TOL_ST_MOTOR_LO   4
`define TOL_ST_BEHAV_LO   8
`define TOL_ST_FAULT_LO   12
`define TOL_ST_OUT_LO     16
`define TOL_RST_LVL_A1    11'h190
`define TOL_RST_LVL_A2    11'h190
`define TOL_RST_LVL_INH   11'h320
`define TOL_RST_LVL_TRIP  11'h3e8
`define TOL_RST_PICKUP    16'h03e8
`define TOL_ONE_POINT_ZERO 16'h0100
`define TOL_LIGHT_LOAD    16'h000a
`define TOL_HIGH_LOAD     16'h07d0
`define TOL_STEP_NS       5000000
`define TOL_CLK_NS        4
`define TOL_MARGIN_NS     5000000
`endif

// ===== verilog/tol_pkg.sv
// types of the thermal overload trip logic
// assumes tol_params.svh sits on the include path
package tol_pkg;
  typedef enum logic [2:0] {
    tol_cond_normal, tol_cond_alarm1, tol_cond_alarm2,
    tol_cond_inhibit, tol_cond_trip, tol_cond_blocked
  } tol_cond_e;
  typedef enum logic [1:0] {
    tol_motor_light, tol_motor_normal, tol_motor_overload, tol_motor_high
  } tol_motor_e;
  typedef enum logic [2:0] {
    tol_behav_on, tol_behav_blocked, tol_behav_test,
    tol_behav_test_blocked, tol_behav_off
  } tol_behav_e;
  typedef logic [10:0] tol_level_t;
  typedef logic [15:0] tol_fix_t;
endpackage

// ===== testbench/tol_partner.sv
// far side of the trip logic: blocking matrix input and the trip relay contact
// assumes the bench requests blocking on block_req, changed just after pclk edges
module tol_partner (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic block_req,
  input  wire logic trip,
  output logic      block_in,
  output logic      contact_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic next_block_in;
  logic next_contact_closed;

  // blocking lands one cycle after the request, well ahead of the delay expiry
  always_comb begin
    next_block_in = block_req;
    next_contact_closed = trip;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_in <= 1'b0;
      contact_closed <= 1'b0;
    end else begin
      block_in <= next_block_in;
      contact_closed <= next_contact_closed;
    end
  end
endmodule

// ===== testbench/tb_tol_trip_logic.sv
// self-checking bench for tol_trip_logic: apb register tasks and protection scenarios
// assumes tol_params.svh on the include path; trip delay steps shortened to STEP cycles
`include "tol_params.svh"
module tb_tol_trip_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import tol_pkg::*;
  localparam int STEP = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, prog_tick = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, block_req = 1'b0, block_in, allow_ln_mode = 1'b0;
  logic [15:0] thermal_cap = 16'h0, meas_current = 16'h0;
  tol_fix_t    service_factor_set = 16'h0180, ambient_k_set = 16'h0180, rated_set = 16'h0180;
  tol_fix_t    service_factor_used, ambient_k_used, rated_used;
  logic        service_factor_bad = 1'b0, ambient_bad = 1'b0, rated_bad = 1'b0;
  logic        ambient_k_incons = 1'b0;
  logic        alarm1, alarm2, inhibit, trip, start, blocked, irq, contact_closed;
  int          failures = 0;
  int          samples_checked = 0;

  always #2 pclk = ~pclk;

  tol_trip_logic #(.STEP_CYC(STEP)) tol_trip_logic_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_tick, .thermal_cap,
    .meas_current, .block_in, .allow_ln_mode, .service_factor_set, .service_factor_bad,
    .ambient_k_set, .ambient_bad, .rated_set, .rated_bad, .ambient_k_incons, .alarm1,
    .alarm2, .inhibit, .trip, .start, .blocked, .service_factor_used, .ambient_k_used,
    .rated_used, .irq);

  tol_partner tol_partner_i (.pclk, .presetn, .block_req, .trip, .block_in, .contact_closed);

  task automatic print_verdict;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, `TOL_OFS_STATUS, 32'h0);
    chk(rd & mask, exp);
  endtask

  task automatic tick(input logic [15:0] cap);
    @(posedge pclk);
    thermal_cap <= cap;
    prog_tick <= 1'b1;
    @(posedge pclk);
    prog_tick <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  function automatic logic [31:0] outs();
    return {26'h0, start, blocked, trip, inhibit, alarm2, alarm1};
  endfunction

  task automatic t_reset;
    rdc(`TOL_OFS_LVL_A1, 32'h190);
    rdc(`TOL_OFS_LVL_A2, 32'h190);
    rdc(`TOL_OFS_LVL_INH, 32'h320);
    rdc(`TOL_OFS_LVL_TRIP, 32'h3e8);
    rdc(`TOL_OFS_TRIP_DLY, 32'h0);
    apb(1'b0, 12'hffc, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask

  task automatic t_levels;
    logic [15:0] caps [6] = '{16'h0, 16'h12b, 16'h12c, 16'h1f4, 16'h258, 16'h257};
    logic [31:0] exp [6] = '{32'h0, 32'h0, 32'h1, 32'h3, 32'h7, 32'h3};
    apb(1'b1, `TOL_OFS_LVL_A1, 32'h12c);
    apb(1'b1, `TOL_OFS_LVL_A2, 32'h1f4);
    apb(1'b1, `TOL_OFS_LVL_INH, 32'h258);
    apb(1'b1, `TOL_OFS_CTRL, 32'h7);
    for (int i = 0; i < 6; i++) begin
      tick(caps[i]);
      chk(outs(), exp[i]);
    end
    tick(16'h12c);
    st(32'h7, 32'h1);
    tick(16'h0);
    st(32'h7, 32'h0);
    apb(1'b1, `TOL_OFS_CTRL, 32'h0);
    tick(16'h258);
    chk(outs(), 32'h0);
  endtask

  task automatic t_trip;
    int n;
    n = 0;
    apb(1'b1, `TOL_OFS_TRIP_DLY, 32'h3);
    apb(1'b1, `TOL_OFS_IRQ_EN, 32'h1);
    apb(1'b1, `TOL_OFS_IRQ_CLR, 32'h3f);
    tick(16'h3e8);
    chk(outs(), 32'h20);
    while (trip !== 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= 3 * STEP && n < 100), 32'h1);
    @(posedge pclk);
    chk({30'h0, contact_closed, irq}, 32'h3);
    st(32'h7, 32'h4);
    rdc(`TOL_OFS_CNT0, 32'h1);
    apb(1'b1, `TOL_OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    apb(1'b1, `TOL_OFS_IRQ_EN, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    apb(1'b1, `TOL_OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
    tick(16'h3e7);
    chk(outs(), 32'h0);
    apb(1'b1, `TOL_OFS_CNT_CLR, 32'h0);
    rdc(`TOL_OFS_CNT0, 32'h0);
  endtask

  // blocking is requested one edge ahead so the partner has it settled at the tick
  task automatic t_block;
    @(posedge pclk);
    block_req <= 1'b1;
    tick(16'h3e8);
    chk(outs(), 32'h10);
    repeat (30) @(posedge pclk);
    chk(32'(trip), 32'h0);
    st(32'h7, 32'h5);
    rdc(12'h040, 32'h1);
    block_req <= 1'b0;
    tick(16'h3e8);
    chk(outs(), 32'h20);
    block_req <= 1'b1;
    tick(16'h3e8);
    chk(outs(), 32'h10);
    repeat (30) @(posedge pclk);
    chk(32'(trip), 32'h0);
    block_req <= 1'b0;
    tick(16'h0);
    apb(1'b1, `TOL_OFS_CTRL, 32'h40);
    allow_ln_mode <= 1'b1;
    tick(16'h3e8);
    chk(outs(), 32'h0);
    st(32'h700, 32'h400);
    // blocked and test-blocked act as blocking, test alone does not
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, `TOL_OFS_CTRL, 32'(m) << 4);
      tick(16'h3e8);
      chk(outs(), (m == 2) ? 32'h20 : 32'h10);
      st(32'h700, 32'(m) << 8);
      tick(16'h0);
    end
    apb(1'b1, `TOL_OFS_CTRL, 32'h0);
    tick(16'h0);
  endtask

  task automatic t_motor;
    logic [15:0] cur [4] = '{16'h9, 16'h1f4, 16'h5dc, 16'h9c4};
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      meas_current <= cur[i];
      tick(16'h0);
      st(32'h30, 32'(i) << 4);
    end
  endtask

  task automatic t_fault;
    tick(16'h0);
    chk({service_factor_used, ambient_k_used}, 32'h01800180);
    chk(32'(rated_used), 32'h0180);
    @(posedge pclk);
    service_factor_bad <= 1'b1;
    ambient_bad <= 1'b1;
    rated_bad <= 1'b1;
    ambient_k_incons <= 1'b1;
    tick(16'h0);
    chk({service_factor_used, ambient_k_used}, 32'h01000100);
    chk(32'(rated_used), 32'h0100);
    st(32'hf000, 32'hf000);
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    // reset values are checked while reset still holds them steady
    chk({25'h0, start, blocked, trip, inhibit, alarm2, alarm1, irq}, 32'h0);
    chk({service_factor_used, rated_used}, 32'h01000100);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_levels();
    t_trip();
    t_block();
    t_motor();
    t_fault();
    print_verdict();
  end
endmodule
